// File: inc/csr_defines.vh
// constants of the core special register set
// assumes inclusion by bare name from the design files
`ifndef CSR_DEFINES_VH
`define CSR_DEFINES_VH

// ****************************************
// core register offsets
// ****************************************
`define CSR_OFS_IND_A 7'h00
`define CSR_OFS_IND_B 7'h01
`define CSR_OFS_PC_LOW 7'h02
`define CSR_OFS_FLAGS 7'h03
`define CSR_OFS_PTRA_LO 7'h04
`define CSR_OFS_PTRA_HI 7'h05
`define CSR_OFS_PTRB_LO 7'h06
`define CSR_OFS_PTRB_HI 7'h07
`define CSR_OFS_BANK 7'h08
`define CSR_OFS_ACC 7'h09
`define CSR_OFS_PC_LATCH 7'h0a
`define CSR_CORE_LIMIT 7'h0c

// ****************************************
// flag bit positions
// ****************************************
`define CSR_BIT_TO 4
`define CSR_BIT_PD 3
`define CSR_BIT_Z 2
`define CSR_BIT_DC 1
`define CSR_BIT_C 0

// ****************************************
// reset values
// ****************************************
`define CSR_RST_BYTE 8'h00
`define CSR_RST_PTR 16'h0000
`define CSR_RST_PC 15'h0000
`define CSR_RST_LATCH 7'h00
`define CSR_RST_BANK 6'h00
`define CSR_RST_TO 1'b1
`define CSR_RST_PD 1'b1
`define CSR_RST_ARITH 1'b0

// ****************************************
// operation codes
// ****************************************
`define CSR_OP_MOVF 4'h0
`define CSR_OP_MOVWF 4'h1
`define CSR_OP_ADD_ACCUMULATOR_TO_FILE 4'h2
`define CSR_OP_SUBTRACT_ACCUMULATOR_FROM_FILE 4'h3
`define CSR_OP_ADD_LITERAL_TO_ACCUMULATOR 4'h4
`define CSR_OP_SUBTRACT_ACCUMULATOR_FROM_LITERAL 4'h5
`define CSR_OP_ROTATE_LEFT_THROUGH_CARRY 4'h6
`define CSR_OP_ROTATE_RIGHT_THROUGH_CARRY 4'h7
`define CSR_OP_ANDWF 4'h8
`define CSR_OP_CLEAR_WATCHDOG_INSTRUCTION 4'h9
`define CSR_OP_SLEEP 4'ha

`endif

// File: rtl/csr_adder8.v
// eight bit adder with carry out of bit 7 and out of bit 3
// assumes the caller inverts the second operand for subtraction
`timescale 1ns/1ps
`default_nettype none

module csr_adder8 (
    // operands
    input wire [7:0] a_in,
    input wire [7:0] b_in,
    input wire cin_in,
    // result
    output wire [7:0] sum_out,
    output wire carry_out,
    output wire nib_carry_out
);

    wire [4:0] lo_sum;
    wire [4:0] hi_sum;

    assign lo_sum = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, cin_in};
    assign hi_sum = {1'b0, a_in[7:4]} + {1'b0, b_in[7:4]} + {4'h0, lo_sum[4]};
    assign sum_out = {hi_sum[3:0], lo_sum[3:0]};
    assign carry_out = hi_sum[4];
    assign nib_carry_out = lo_sum[4];

endmodule // csr_adder8

`default_nettype wire

// File: rtl/csr_core_regs.v
// core special register set: pointers, flags, accumulator, bank, pc
// assumes a data memory with one cycle registered read and single-cycle write
`timescale 1ns/1ps
`default_nettype none
`include "csr_defines.vh"

// Notes on behaviour
// - access to port a really reaches memory at pointer a; port stores nothing.
// - access to port b really reaches memory at pointer b; port stores nothing.
// - pc low byte reads and writes pc bits 7:0, resets to zero.
// - timeout flag set at power-up, watchdog clear, sleep; cleared on watchdog timeout.
// - powerdown flag set at power-up and watchdog clear; cleared by sleep.
// - zero flag reflects zero result; cleared on power-on, kept on other resets.
// - nibble carry is carry out of bit 3 for add and subtract.
// - carry is carry out of bit 7 for add and subtract.
// - after subtraction carry flags read one when no borrow happened.
// - subtraction adds the two's complement of the second operand.
// - rotates through carry load carry with the bit shifted out.
// - pointer a is sixteen bits, reset zero, bytes written separately.
// - pointer b is sixteen bits, reset zero, bytes written separately.
// - bank select six bits gives address bits 12:7 of direct accesses.
// - memory reachable directly through bank or indirectly through pointers, except addresses with bits 15:13 zero and bits 6:0 below 0x0c.
// - pc high latch is seven bits, reset zero, buffers upper pc bits.
// - writing pc low byte copies the latch into pc bits 14:8.
// - pointer at an indirect port reads zero and suppresses the write.
// - pc is fifteen bits and cleared on every reset.
module csr_core_regs (
    // clock and resets
    input wire ref_clk_in,
    input wire rst_in,
    input wire other_reset_in,
    input wire wdt_timeout_in,
    // operation request
    input wire op_valid_in,
    input wire [3:0] op_code_in,
    input wire [6:0] file_addr_in,
    input wire dest_acc_in,
    input wire [7:0] literal_in,
    input wire pc_inc_in,
    // operation answer and state
    output reg busy_out,
    output reg done_out,
    output reg [7:0] result_out,
    output reg [7:0] acc_out,
    output reg [4:0] flags_out,
    output reg [14:0] pc_out,
    output reg [5:0] bank_out,
    // data memory
    output reg [15:0] mem_addr_out,
    output reg mem_rd_out,
    output reg mem_wr_out,
    output reg [7:0] mem_wdata_out,
    input wire [7:0] mem_rdata_in
);

    // ****************************************
    // state and registers
    // ****************************************
    localparam ST_IDLE = 2'd0;
    localparam ST_READ = 2'd1;
    localparam ST_EXEC = 2'd2;

    reg [1:0] state_r;
    reg [15:0] ptr_a_r;
    reg [15:0] ptr_b_r;
    reg [6:0] latch_r;
    reg [3:0] op_r;
    reg dest_acc_r;
    reg [7:0] opnd_r;
    reg src_ext_r;
    reg null_r;
    reg core_r;
    reg [6:0] core_addr_r;

    // ****************************************
    // address formation
    // ****************************************
    reg [15:0] ea_nxt;
    reg is_null;
    reg is_core;
    reg [7:0] core_rd;
    reg uses_file;
    reg reads_file;

    always @* begin
        if (file_addr_in == `CSR_OFS_IND_A) begin
            ea_nxt = ptr_a_r;
        end else if (file_addr_in == `CSR_OFS_IND_B) begin
            ea_nxt = ptr_b_r;
        end else begin
            ea_nxt = {3'h0, bank_out, file_addr_in};
        end
        is_null = (ea_nxt[15:13] == 3'h0) && (ea_nxt[6:1] == 6'h00);
        is_core = (ea_nxt[15:13] == 3'h0) && (ea_nxt[6:0] < `CSR_CORE_LIMIT);
        uses_file = (op_code_in != `CSR_OP_ADD_LITERAL_TO_ACCUMULATOR) && (op_code_in != `CSR_OP_SUBTRACT_ACCUMULATOR_FROM_LITERAL) &&
            (op_code_in != `CSR_OP_CLEAR_WATCHDOG_INSTRUCTION) && (op_code_in != `CSR_OP_SLEEP);
        reads_file = uses_file && (op_code_in != `CSR_OP_MOVWF);
    end

    // ****************************************
    // core register read decode
    // ****************************************
    always @* begin
        if (is_null) begin
            core_rd = `CSR_RST_BYTE;
        end else if (ea_nxt[6:0] == `CSR_OFS_PC_LOW) begin
            core_rd = pc_out[7:0];
        end else if (ea_nxt[6:0] == `CSR_OFS_FLAGS) begin
            core_rd = {3'h0, flags_out};
        end else if (ea_nxt[6:0] == `CSR_OFS_PTRA_LO) begin
            core_rd = ptr_a_r[7:0];
        end else if (ea_nxt[6:0] == `CSR_OFS_PTRA_HI) begin
            core_rd = ptr_a_r[15:8];
        end else if (ea_nxt[6:0] == `CSR_OFS_PTRB_LO) begin
            core_rd = ptr_b_r[7:0];
        end else if (ea_nxt[6:0] == `CSR_OFS_PTRB_HI) begin
            core_rd = ptr_b_r[15:8];
        end else if (ea_nxt[6:0] == `CSR_OFS_BANK) begin
            core_rd = {2'h0, bank_out};
        end else if (ea_nxt[6:0] == `CSR_OFS_ACC) begin
            core_rd = acc_out;
        end else if (ea_nxt[6:0] == `CSR_OFS_PC_LATCH) begin
            core_rd = {1'b0, latch_r};
        end else begin
            core_rd = `CSR_RST_BYTE;
        end
    end

    // ****************************************
    // execute datapath
    // ****************************************
    reg [7:0] opnd;
    reg is_sub;
    reg is_arith;
    reg [7:0] res;
    reg res_to_acc;
    reg res_to_file;
    reg upd_z;
    reg upd_c;
    reg new_c;
    wire [7:0] add_sum;
    wire add_c;
    wire add_dc;

    always @* begin
        opnd = src_ext_r ? mem_rdata_in : opnd_r;
        is_sub = (op_r == `CSR_OP_SUBTRACT_ACCUMULATOR_FROM_FILE) || (op_r == `CSR_OP_SUBTRACT_ACCUMULATOR_FROM_LITERAL);
        is_arith = is_sub || (op_r == `CSR_OP_ADD_ACCUMULATOR_TO_FILE) || (op_r == `CSR_OP_ADD_LITERAL_TO_ACCUMULATOR);
        res = opnd;
        upd_z = 1'b0;
        upd_c = 1'b0;
        new_c = add_c;
        res_to_acc = dest_acc_r;
        res_to_file = !dest_acc_r;
        if (is_arith) begin
            res = add_sum;
            upd_z = 1'b1;
            upd_c = 1'b1;
        end else if (op_r == `CSR_OP_MOVF) begin
            upd_z = 1'b1;
        end else if (op_r == `CSR_OP_MOVWF) begin
            res = acc_out;
            res_to_acc = 1'b0;
            res_to_file = 1'b1;
        end else if (op_r == `CSR_OP_ANDWF) begin
            res = opnd & acc_out;
            upd_z = 1'b1;
        end else if (op_r == `CSR_OP_ROTATE_LEFT_THROUGH_CARRY) begin
            res = {opnd[6:0], flags_out[`CSR_BIT_C]};
            upd_c = 1'b1;
            new_c = opnd[7];
        end else if (op_r == `CSR_OP_ROTATE_RIGHT_THROUGH_CARRY) begin
            res = {flags_out[`CSR_BIT_C], opnd[7:1]};
            upd_c = 1'b1;
            new_c = opnd[0];
        end else begin
            res_to_acc = 1'b0;
            res_to_file = 1'b0;
        end
        if ((op_r == `CSR_OP_ADD_LITERAL_TO_ACCUMULATOR) || (op_r == `CSR_OP_SUBTRACT_ACCUMULATOR_FROM_LITERAL)) begin
            res_to_acc = 1'b1;
            res_to_file = 1'b0;
        end
    end

    // subtraction as addition of the inverted operand plus one
    csr_adder8 u_adder (
        .a_in(opnd),
        .b_in(is_sub ? ~acc_out : acc_out),
        .cin_in(is_sub),
        .sum_out(add_sum),
        .carry_out(add_c),
        .nib_carry_out(add_dc)
    );

    wire exec_now = (state_r == ST_EXEC);
    wire core_wr = exec_now && res_to_file && core_r && !null_r;

    // ****************************************
    // sequencer and memory port
    // ****************************************
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= ST_IDLE;
            op_r <= `CSR_OP_MOVF;
            dest_acc_r <= 1'b0;
            opnd_r <= `CSR_RST_BYTE;
            src_ext_r <= 1'b0;
            null_r <= 1'b0;
            core_r <= 1'b0;
            core_addr_r <= `CSR_OFS_IND_A;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            result_out <= `CSR_RST_BYTE;
            mem_addr_out <= `CSR_RST_PTR;
            mem_rd_out <= 1'b0;
            mem_wr_out <= 1'b0;
            mem_wdata_out <= `CSR_RST_BYTE;
        end else if (other_reset_in) begin
            state_r <= ST_IDLE;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            mem_rd_out <= 1'b0;
            mem_wr_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            mem_rd_out <= 1'b0;
            mem_wr_out <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (op_valid_in) begin
                        op_r <= op_code_in;
                        dest_acc_r <= dest_acc_in;
                        null_r <= uses_file && is_null;
                        core_r <= uses_file && is_core;
                        core_addr_r <= ea_nxt[6:0];
                        mem_addr_out <= ea_nxt;
                        busy_out <= 1'b1;
                        src_ext_r <= 1'b0;
                        opnd_r <= uses_file ? core_rd : literal_in;
                        if (reads_file && !is_core) begin
                            mem_rd_out <= 1'b1;
                            src_ext_r <= 1'b1;
                            state_r <= ST_READ;
                        end else begin
                            state_r <= ST_EXEC;
                        end
                    end
                end
                ST_READ: begin
                    state_r <= ST_EXEC;
                end
                ST_EXEC: begin
                    result_out <= res;
                    done_out <= 1'b1;
                    busy_out <= 1'b0;
                    if (res_to_file && !core_r && !null_r) begin
                        mem_wr_out <= 1'b1;
                        mem_wdata_out <= res;
                    end
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // core registers and flags
    // ****************************************
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ptr_a_r <= `CSR_RST_PTR;
            ptr_b_r <= `CSR_RST_PTR;
            latch_r <= `CSR_RST_LATCH;
            bank_out <= `CSR_RST_BANK;
            acc_out <= `CSR_RST_BYTE;
            pc_out <= `CSR_RST_PC;
            flags_out[`CSR_BIT_TO] <= `CSR_RST_TO;
            flags_out[`CSR_BIT_PD] <= `CSR_RST_PD;
            flags_out[`CSR_BIT_Z] <= `CSR_RST_ARITH;
            flags_out[`CSR_BIT_DC] <= `CSR_RST_ARITH;
            flags_out[`CSR_BIT_C] <= `CSR_RST_ARITH;
        end else if (other_reset_in) begin
            // arithmetic flags and power flags hold
            ptr_a_r <= `CSR_RST_PTR;
            ptr_b_r <= `CSR_RST_PTR;
            latch_r <= `CSR_RST_LATCH;
            bank_out <= `CSR_RST_BANK;
            acc_out <= `CSR_RST_BYTE;
            pc_out <= `CSR_RST_PC;
        end else begin
            if (pc_inc_in) begin
                pc_out <= pc_out + 15'h0001;
            end
            if (exec_now && res_to_acc) begin
                acc_out <= res;
            end
            if (core_wr) begin
                if (core_addr_r == `CSR_OFS_PC_LOW) begin
                    pc_out <= {latch_r, res};
                end else if (core_addr_r == `CSR_OFS_FLAGS) begin
                    flags_out[`CSR_BIT_Z] <= res[`CSR_BIT_Z];
                    flags_out[`CSR_BIT_DC] <= res[`CSR_BIT_DC];
                    flags_out[`CSR_BIT_C] <= res[`CSR_BIT_C];
                end else if (core_addr_r == `CSR_OFS_PTRA_LO) begin
                    ptr_a_r[7:0] <= res;
                end else if (core_addr_r == `CSR_OFS_PTRA_HI) begin
                    ptr_a_r[15:8] <= res;
                end else if (core_addr_r == `CSR_OFS_PTRB_LO) begin
                    ptr_b_r[7:0] <= res;
                end else if (core_addr_r == `CSR_OFS_PTRB_HI) begin
                    ptr_b_r[15:8] <= res;
                end else if (core_addr_r == `CSR_OFS_BANK) begin
                    bank_out <= res[5:0];
                end else if (core_addr_r == `CSR_OFS_ACC) begin
                    acc_out <= res;
                end else if (core_addr_r == `CSR_OFS_PC_LATCH) begin
                    latch_r <= res[6:0];
                end
            end
            if (exec_now && upd_z) begin
                flags_out[`CSR_BIT_Z] <= (res == 8'h00);
            end
            if (exec_now && upd_c) begin
                flags_out[`CSR_BIT_C] <= new_c;
            end
            if (exec_now && is_arith) begin
                flags_out[`CSR_BIT_DC] <= add_dc;
            end
            if (wdt_timeout_in) begin
                flags_out[`CSR_BIT_TO] <= 1'b0;
            end
            if (exec_now && (op_r == `CSR_OP_CLEAR_WATCHDOG_INSTRUCTION)) begin
                flags_out[`CSR_BIT_TO] <= 1'b1;
                flags_out[`CSR_BIT_PD] <= 1'b1;
            end
            if (exec_now && (op_r == `CSR_OP_SLEEP)) begin
                flags_out[`CSR_BIT_TO] <= 1'b1;
                flags_out[`CSR_BIT_PD] <= 1'b0;
            end
        end
    end

endmodule // csr_core_regs

`default_nettype wire

// File: sim/csr_core_regs_assertions.sv
// port assertions for the core special register set
// assumes it is bound to csr_core_regs, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "csr_defines.vh"
module csr_core_regs_assertions (
    // clock and resets
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic other_reset_in,
    input wire logic wdt_timeout_in,
    // operation request
    input wire logic op_valid_in,
    input wire logic [3:0] op_code_in,
    input wire logic [7:0] literal_in,
    input wire logic pc_inc_in,
    // answer and state
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic [7:0] acc_out,
    input wire logic [4:0] flags_out,
    input wire logic [14:0] pc_out,
    input wire logic mem_rd_out,
    input wire logic mem_wr_out
);
    // ****
    // assertions
    // ****
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);
    wire take = op_valid_in && !busy_out && !other_reset_in;
    property p_rst;
        disable iff (1'b0) rst_in |=> flags_out == 5'h18 && pc_out == 15'h0 && acc_out == 8'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    property p_rd;
        mem_rd_out |-> !done_out ##2 done_out;
    endproperty
    a_rd: assert property (p_rd) else $error("indirect read late");
    property p_wr;
        mem_wr_out |-> done_out && !busy_out;
    endproperty
    a_wr: assert property (p_wr) else $error("write off done");
    property p_take;
        take |=> busy_out ##[1:2] done_out;
    endproperty
    a_take: assert property (p_take) else $error("op not finished");
    property p_pcinc;
        pc_inc_in && !busy_out && !other_reset_in |=> pc_out == $past(pc_out) + 15'h1;
    endproperty
    a_pcinc: assert property (p_pcinc) else $error("pc step wrong");
    property p_orst;
        other_reset_in |=> pc_out == 15'h0 && flags_out == $past(flags_out);
    endproperty
    a_orst: assert property (p_orst) else $error("other reset wrong");
    property p_wdt;
        wdt_timeout_in && !busy_out |=> !flags_out[`CSR_BIT_TO];
    endproperty
    a_wdt: assert property (p_wdt) else $error("timeout flag kept");
    property p_sleep;
        take && op_code_in == `CSR_OP_SLEEP |-> ##2 flags_out[4:3] == 2'b10;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
    property p_clr;
        take && op_code_in == `CSR_OP_CLEAR_WATCHDOG_INSTRUCTION |-> ##2 flags_out[4:3] == 2'b11;
    endproperty
    a_clr: assert property (p_clr) else $error("clear flags wrong");
    property p_add;
        take && op_code_in == `CSR_OP_ADD_LITERAL_TO_ACCUMULATOR |-> ##2
            {flags_out[0], acc_out} == {1'b0, $past(acc_out, 2)} + {1'b0, $past(literal_in, 2)};
    endproperty
    a_add: assert property (p_add) else $error("add result wrong");
    c_wr: cover property (mem_wr_out);
    c_rd: cover property (mem_rd_out);
    c_sleep: cover property (take && op_code_in == `CSR_OP_SLEEP);
endmodule // csr_core_regs_assertions
bind csr_core_regs csr_core_regs_assertions chk_u (.*);
`default_nettype wire

// File: sim/csr_mem_model.sv
// data memory model on the far side of the core register set
// assumes one cycle registered read and single-cycle write
`timescale 1ns/1ps
`default_nettype none
module csr_mem_model (
    // clock
    input wire logic ref_clk_in,
    // access
    input wire logic [15:0] addr_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    output var logic [7:0] rdata_out
);
    // ****
    // storage
    // ****
    logic [7:0] mem [0:65535];
    initial rdata_out = 8'h00;
    always @(posedge ref_clk_in) begin
        if (wr_in) begin
            mem[addr_in] <= wdata_in;
        end
        // stale data toggles so it is never mistaken for a read
        rdata_out <= rd_in ? mem[addr_in] : ~rdata_out;
    end
endmodule // csr_mem_model
`default_nettype wire

// File: sim/tb_csr_core_regs.sv
// self-checking bench for the core special register set
// assumes csr_core_regs with the data memory model on its far side
`timescale 1ns/1ps
`default_nettype none
`include "csr_defines.vh"
module tb_csr_core_regs;
    // ****
    // stimulus and wiring
    // ****
    logic ref_clk_in, rst_in, other_reset_in, wdt_timeout_in, op_valid_in, dest_acc_in;
    logic pc_inc_in, busy_out, done_out, mem_rd_out, mem_wr_out;
    logic [3:0] op_code_in;
    logic [6:0] file_addr_in;
    logic [7:0] literal_in, result_out, acc_out, mem_wdata_out, mem_rdata_in;
    logic [4:0] flags_out, f;
    logic [14:0] pc_out;
    logic [5:0] bank_out, bnk;
    logic [15:0] mem_addr_out;
    logic [10:0] e;
    int errors = 0;
    int checked = 0;
    int i;
    logic [3:0] tc [6] = '{`CSR_OP_ADD_LITERAL_TO_ACCUMULATOR, `CSR_OP_ADD_LITERAL_TO_ACCUMULATOR, `CSR_OP_SUBTRACT_ACCUMULATOR_FROM_LITERAL, `CSR_OP_SUBTRACT_ACCUMULATOR_FROM_LITERAL,
        `CSR_OP_ADD_ACCUMULATOR_TO_FILE, `CSR_OP_SUBTRACT_ACCUMULATOR_FROM_FILE};
    logic [7:0] ta [6] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h80, 8'h10};
    logic [7:0] tw [6] = '{8'h0f, 8'hff, 8'h01, 8'h01, 8'h80, 8'h01};
    csr_core_regs dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .other_reset_in(other_reset_in), .wdt_timeout_in(wdt_timeout_in),
        .op_valid_in(op_valid_in), .op_code_in(op_code_in), .file_addr_in(file_addr_in),
        .dest_acc_in(dest_acc_in), .literal_in(literal_in), .pc_inc_in(pc_inc_in),
        .busy_out(busy_out), .done_out(done_out), .result_out(result_out),
        .acc_out(acc_out), .flags_out(flags_out), .pc_out(pc_out), .bank_out(bank_out),
        .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
        .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in));
    csr_mem_model mem_u (.ref_clk_in(ref_clk_in), .addr_in(mem_addr_out),
        .rd_in(mem_rd_out), .wr_in(mem_wr_out), .wdata_in(mem_wdata_out),
        .rdata_out(mem_rdata_in));
    initial begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    // ****
    // tasks
    // ****
    task automatic close_out();
        if (errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] x);
        checked++;
        if (s !== x) begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, s, x);
        end
    endtask
    task automatic op(input logic [3:0] c, input logic [6:0] a, input logic d,
        input logic [7:0] l);
        int n;
        @(negedge ref_clk_in);
        op_valid_in = 1'b1;
        op_code_in = c;
        file_addr_in = a;
        dest_acc_in = d;
        literal_in = l;
        @(negedge ref_clk_in);
        op_valid_in = 1'b0;
        n = 0;
        while (done_out !== 1'b1 && n < 8) begin
            @(negedge ref_clk_in);
            n++;
        end
        if (n == 8) begin
            errors++;
            close_out();
        end
    endtask
    task automatic rd(input logic [6:0] a);
        op(`CSR_OP_MOVF, a, 1'b1, 8'h00);
    endtask
    task automatic setacc(input logic [7:0] v);
        mem_u.mem[{3'b000, bnk, 7'h70}] = v;
        rd(7'h70);
    endtask
    task automatic working_accumulator(input logic [6:0] a, input logic [7:0] v);
        setacc(v);
        op(`CSR_OP_MOVWF, a, 1'b0, 8'h00);
    endtask
    function automatic logic [10:0] ar(input logic [7:0] a, input logic [7:0] b,
        input logic s);
        logic [8:0] t;
        logic [4:0] n;
        logic [7:0] bb;
        bb = s ? ~b : b;
        t = {1'b0, a} + {1'b0, bb} + {8'h00, s};
        n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, s};
        return {t[8], n[4], t[7:0] == 8'h00, t[7:0]};
    endfunction
    // ****
    // sequence
    // ****
    initial begin
        {rst_in, other_reset_in, wdt_timeout_in, op_valid_in, dest_acc_in, pc_inc_in} = 6'h20;
        {op_code_in, file_addr_in, literal_in} = 19'h0;
        bnk = 6'h00;
        repeat (20) @(negedge ref_clk_in);
        rst_in = 1'b0;
        chk(flags_out, 5'h18);
        chk(pc_out, 15'h0000);
        for (i = 0; i < 11; i++) begin
            if (i != 3) begin
                rd(i[6:0]);
                chk(result_out, 8'h00);
            end
        end
        working_accumulator(7'h04, 8'h23);
        working_accumulator(7'h05, 8'h01);
        working_accumulator(7'h06, 8'h56);
        working_accumulator(7'h07, 8'h04);
        working_accumulator(7'h0a, 8'hff);
        rd(7'h05);
        chk(result_out, 8'h01);
        rd(7'h07);
        chk(result_out, 8'h04);
        rd(7'h0a);
        chk(result_out, 8'h7f);
        mem_u.mem[16'h0123] = 8'h5a;
        rd(7'h00);
        chk(result_out, 8'h5a);
        chk(mem_addr_out, 16'h0123);
        setacc(8'h3c);
        op(`CSR_OP_MOVWF, 7'h01, 1'b0, 8'h00);
        @(negedge ref_clk_in);
        chk(mem_u.mem[16'h0456], 8'h3c);
        working_accumulator(7'h04, 8'h01);
        working_accumulator(7'h05, 8'h00);
        rd(7'h00);
        chk(result_out, 8'h00);
        working_accumulator(7'h0a, 8'h15);
        working_accumulator(7'h02, 8'h34);
        chk(pc_out, 15'h1534);
        pc_inc_in = 1'b1;
        repeat (3) @(negedge ref_clk_in);
        pc_inc_in = 1'b0;
        chk(pc_out, 15'h1537);
        rd(7'h02);
        chk(result_out, 8'h37);
        working_accumulator(7'h08, 8'hff);
        bnk = 6'h3f;
        chk(bank_out, 6'h3f);
        mem_u.mem[16'h1fa0] = 8'h99;
        rd(7'h20);
        chk(result_out, 8'h99);
        chk(mem_addr_out, 16'h1fa0);
        working_accumulator(7'h08, 8'h00);
        bnk = 6'h00;
        for (i = 0; i < 6; i++) begin
            mem_u.mem[16'h0030] = ta[i];
            setacc(tw[i]);
            e = ar(ta[i], tw[i], tc[i][0]);
            op(tc[i], 7'h30, 1'b1, ta[i]);
            chk(acc_out, e[7:0]);
            chk(flags_out[2:0], {e[8], e[9], e[10]});
        end
        mem_u.mem[16'h0030] = 8'h80;
        setacc(8'h80);
        op(`CSR_OP_ADD_ACCUMULATOR_TO_FILE, 7'h30, 1'b0, 8'h00);
        @(negedge ref_clk_in);
        chk(mem_u.mem[16'h0030], 8'h00);
        chk(flags_out[2:0], 3'b101);
        mem_u.mem[16'h0031] = 8'h82;
        op(`CSR_OP_ROTATE_RIGHT_THROUGH_CARRY, 7'h31, 1'b1, 8'h00);
        chk({acc_out, flags_out[0]}, 9'h182);
        op(`CSR_OP_ROTATE_LEFT_THROUGH_CARRY, 7'h31, 1'b1, 8'h00);
        chk({acc_out, flags_out[0]}, 9'h009);
        wdt_timeout_in = 1'b1;
        @(negedge ref_clk_in);
        wdt_timeout_in = 1'b0;
        chk(flags_out[4:3], 2'b01);
        op(`CSR_OP_CLEAR_WATCHDOG_INSTRUCTION, 7'h00, 1'b0, 8'h00);
        chk(flags_out[4:3], 2'b11);
        op(`CSR_OP_SLEEP, 7'h00, 1'b0, 8'h00);
        chk(flags_out[4:3], 2'b10);
        f = flags_out;
        other_reset_in = 1'b1;
        @(negedge ref_clk_in);
        other_reset_in = 1'b0;
        chk(pc_out, 15'h0000);
        chk(flags_out, f);
        rst_in = 1'b1;
        @(negedge ref_clk_in);
        rst_in = 1'b0;
        chk(flags_out, 5'h18);
        close_out();
    end
endmodule // tb_csr_core_regs
`default_nettype wire
